// ---- include/clock_system_regs.vh ----
`ifndef CLOCK_SYSTEM_REGS_VH
`define CLOCK_SYSTEM_REGS_VH
// Register index of each word; its byte address is four times the index.
`define IDX_TAP_MOD      10'h000
`define IDX_TRIM_RANGE   10'h002
`define IDX_LOOP_DIVMUL  10'h004
`define IDX_LOOP_REF     10'h006
`define IDX_SRC_SEL      10'h008
`define IDX_DIV_GATE     10'h00A
`define IDX_AUX_XTAL     10'h00C
`define IDX_STATUS       10'h007
`define OFS_TAP_MOD      {`IDX_TAP_MOD, 2'b00}
`define OFS_TRIM_RANGE   {`IDX_TRIM_RANGE, 2'b00}
`define OFS_LOOP_DIVMUL  {`IDX_LOOP_DIVMUL, 2'b00}
`define OFS_LOOP_REF     {`IDX_LOOP_REF, 2'b00}
`define OFS_SRC_SEL      {`IDX_SRC_SEL, 2'b00}
`define OFS_DIV_GATE     {`IDX_DIV_GATE, 2'b00}
`define OFS_AUX_XTAL     {`IDX_AUX_XTAL, 2'b00}
`define OFS_STATUS       {`IDX_STATUS, 2'b00}
`define RST_TAP_MOD      16'h0000
`define RST_TRIM_RANGE   16'h0033
`define RST_LOOP_DIVMUL  16'h101F
`define RST_LOOP_REF     16'h0000
`define RST_SRC_SEL      16'h0100
`define RST_DIV_GATE     16'h1000
`define RST_AUX_XTAL     16'h08C1
`define MASK_TAP_MOD     16'h3FFF
`define MASK_TRIM_RANGE  16'h00FF
`define MASK_LOOP_DIVMUL 16'h73FF
`define MASK_LOOP_REF    16'h0037
`define MASK_SRC_SEL     16'h0107
`define MASK_DIV_GATE    16'h1137
`define MASK_AUX_XTAL    16'h0FFF
`define MOD_MSB          13
`define MOD_LSB          9
`define TAP_MSB          8
`define FACTORY_TRIM     3'h3
`define MOD_MAX          5'h1F
`endif

// ---- rtl/pow2_divider.v ----
`default_nettype none
// ----------------------------------------------------------------------------
// Power-of-two enable divider.
// ----------------------------------------------------------------------------
// Emits a one-cycle pulse every 2**code input enables.
module pow2_divider (
  // Clock and reset.
  input  wire       pclk,
  input  wire       presetn,
  // Input enable and ratio.
  input  wire       en_in,
  input  wire [2:0] code,
  // Divided enable.
  output reg        en_out
);
  reg  [6:0] cnt_ff;
  wire [6:0] limit;

  assign limit = (7'h01 << code) - 7'h01;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 7'h00;
      en_out <= 1'b0;
    end else begin
      en_out <= 1'b0;
      if (en_in) begin
        if (cnt_ff >= limit) begin
          cnt_ff <= 7'h00;
          en_out <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 7'h01;
        end
      end
    end
  end
endmodule // pow2_divider
`default_nettype wire

// ---- rtl/pin_sync.v ----
`default_nettype none
// ----------------------------------------------------------------------------
// Three-stage pin synchroniser.
// ----------------------------------------------------------------------------
// The output follows once stages two and three agree.
module pin_sync (
  // Clock and reset.
  input  wire pclk,
  input  wire presetn,
  // Pin and result.
  input  wire pin_in,
  output reg  level
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level <= s3_ff;
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

// ---- rtl/clock_system_config_regs.v ----
// The placing of the registers and the APB register port were decided locally.
`include "clock_system_regs.vh"
`default_nettype none
// ----------------------------------------------------------------------------
// Clock system configuration registers with APB access.
// ----------------------------------------------------------------------------
// Clock sources arrive as enable strobes in pclk; clock outputs are enable pulses.
module clock_system_config_regs #(
  parameter HF_SUPPORT = 1'b1,
  parameter XTAL_32K_ONLY = 1'b0
) (
  // APB clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Frequency loop steps and source strobes.
  input  wire        loop_up_pin,
  input  wire        loop_down_pin,
  input  wire        osc_tick,
  input  wire        ref_tick,
  input  wire        xtal_tick,
  input  wire        lp_tick,
  input  wire        lp_in_use,
  // Clock outputs and analog controls.
  output reg         main_clk_en,
  output reg         sub_clk_en,
  output reg         aux_clk_en,
  output reg         loop_ref_en,
  output reg  [8:0]  oscillator_tap,
  output reg  [2:0]  applied_trim,
  output reg  [2:0]  range_select,
  output reg         lp_osc_on,
  output reg         crystal_bypass,
  output reg  [1:0]  crystal_high_band,
  output reg  [1:0]  crystal_drive_strength
);

  // --------------------------------------------------------------------------
  // Register storage.
  // --------------------------------------------------------------------------
  reg  [15:0] tap_mod_ff;
  reg  [15:0] trim_range_ff;
  reg  [15:0] loop_divmul_ff;
  reg  [15:0] loop_ref_ff;
  reg  [15:0] src_sel_ff;
  reg  [15:0] div_gate_ff;
  reg  [15:0] aux_xtal_ff;
  reg  [15:0] nxt_word;
  reg  [15:0] rd_word;
  reg         rd_hit;
  wire        wr_acc;
  wire        loop_up;
  wire        loop_down;
  wire [15:0] wmask;
  // Status view of the sub clock gate and of the auxiliary divider bypass.
  wire        sub_clk_gate = div_gate_ff[8];
  wire        aux_bypass   = ~src_sel_ff[8] & ~aux_xtal_ff[5];

  assign wr_acc = psel & penable & pwrite & pready;
  assign wmask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  pin_sync u_up (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (loop_up_pin),
    .level   (loop_up)
  );

  pin_sync u_dn (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (loop_down_pin),
    .level   (loop_down)
  );

  // Edge detection on the synchronised loop steps.
  reg  up_d_ff;
  reg  dn_d_ff;
  wire up_step;
  wire dn_step;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_d_ff <= 1'b0;
      dn_d_ff <= 1'b0;
    end else begin
      up_d_ff <= loop_up;
      dn_d_ff <= loop_down;
    end
  end

  assign up_step = loop_up & ~up_d_ff;
  assign dn_step = loop_down & ~dn_d_ff;

  // Merges write data by byte lane over a current word.
  function [15:0] merge;
    input [15:0] cur;
    input [15:0] wd;
    input [15:0] lanes;
    input [15:0] keep;
    begin
      merge = ((cur & ~lanes) | (wd & lanes)) & keep;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Modulation counter and tap.
  // --------------------------------------------------------------------------
  wire [4:0] mod_cnt = tap_mod_ff[`MOD_MSB:`MOD_LSB];
  wire [8:0] tap_cur = tap_mod_ff[`TAP_MSB:0];
  reg  [4:0] nxt_mod;
  reg  [8:0] nxt_tap;

  always @* begin
    nxt_mod = mod_cnt;
    nxt_tap = tap_cur;
    if (up_step && !dn_step) begin
      if (trim_range_ff[0]) begin
        nxt_tap = tap_cur + 9'h001;
      end else begin
        nxt_mod = mod_cnt + 5'h01;
        if (mod_cnt == `MOD_MAX) begin
          nxt_tap = tap_cur + 9'h001;
        end
      end
    end else if (dn_step && !up_step) begin
      if (trim_range_ff[0]) begin
        nxt_tap = tap_cur - 9'h001;
      end else begin
        nxt_mod = mod_cnt - 5'h01;
        if (mod_cnt == 5'h00) begin
          nxt_tap = tap_cur - 9'h001;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_mod_ff <= `RST_TAP_MOD;
    end else if (wr_acc && paddr == `OFS_TAP_MOD) begin
      tap_mod_ff <= merge(tap_mod_ff, pwdata[15:0], wmask, `MASK_TAP_MOD);
    end else begin
      tap_mod_ff <= {2'b00, nxt_mod, nxt_tap};
    end
  end

  // --------------------------------------------------------------------------
  // Configuration writes.
  // --------------------------------------------------------------------------
  always @* begin
    nxt_word = merge(loop_divmul_ff, pwdata[15:0], wmask, `MASK_LOOP_DIVMUL);
    if (nxt_word[14:13] == 2'b11) begin
      nxt_word[14:12] = loop_divmul_ff[14:12];
    end
    if (nxt_word[9:0] == 10'h000) begin
      nxt_word[9:0] = 10'h001;
    end
  end

  reg [15:0] nxt_ref;
  reg [15:0] nxt_src;
  reg [15:0] nxt_aux;

  always @* begin
    nxt_ref = merge(loop_ref_ff, pwdata[15:0], wmask, `MASK_LOOP_REF);
    if (nxt_ref[5]) begin
      nxt_ref[5:4] = loop_ref_ff[5:4];
    end
    if (nxt_ref[2:0] > 3'h4) begin
      nxt_ref[2:0] = loop_ref_ff[2:0];
    end
    if (XTAL_32K_ONLY) begin
      nxt_ref[2:0] = 3'h0;
    end
    nxt_src = merge(src_sel_ff, pwdata[15:0], wmask, `MASK_SRC_SEL);
    if (nxt_src[2]) begin
      nxt_src[2:0] = src_sel_ff[2:0];
    end
    nxt_aux = merge(aux_xtal_ff, pwdata[15:0], wmask, `MASK_AUX_XTAL);
    if (nxt_aux[11:8] > 4'h9) begin
      nxt_aux[11:8] = aux_xtal_ff[11:8];
    end
    if (!HF_SUPPORT) begin
      nxt_aux[5] = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_range_ff  <= `RST_TRIM_RANGE;
      loop_divmul_ff <= `RST_LOOP_DIVMUL;
      loop_ref_ff    <= `RST_LOOP_REF;
      src_sel_ff     <= `RST_SRC_SEL;
      div_gate_ff    <= `RST_DIV_GATE;
      aux_xtal_ff    <= `RST_AUX_XTAL;
    end else if (wr_acc) begin
      case (paddr)
        `OFS_TRIM_RANGE: begin
          trim_range_ff <= merge(trim_range_ff, pwdata[15:0], wmask, `MASK_TRIM_RANGE);
        end
        `OFS_LOOP_DIVMUL: begin
          loop_divmul_ff <= nxt_word;
        end
        `OFS_LOOP_REF: begin
          loop_ref_ff <= nxt_ref;
        end
        `OFS_SRC_SEL: begin
          src_sel_ff <= nxt_src;
        end
        `OFS_DIV_GATE: begin
          div_gate_ff <= merge(div_gate_ff, pwdata[15:0], wmask, `MASK_DIV_GATE);
        end
        `OFS_AUX_XTAL: begin
          aux_xtal_ff <= nxt_aux;
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // APB read and response.
  // --------------------------------------------------------------------------
  always @* begin
    rd_hit  = 1'b1;
    rd_word = 16'h0000;
    case (paddr)
      `OFS_TAP_MOD:     rd_word = tap_mod_ff & `MASK_TAP_MOD;
      `OFS_TRIM_RANGE:  rd_word = trim_range_ff & `MASK_TRIM_RANGE;
      `OFS_LOOP_DIVMUL: rd_word = loop_divmul_ff & `MASK_LOOP_DIVMUL;
      `OFS_LOOP_REF:    rd_word = loop_ref_ff & `MASK_LOOP_REF;
      `OFS_SRC_SEL:     rd_word = src_sel_ff & `MASK_SRC_SEL;
      `OFS_DIV_GATE:    rd_word = div_gate_ff & `MASK_DIV_GATE;
      `OFS_AUX_XTAL:    rd_word = aux_xtal_ff & `MASK_AUX_XTAL;
      `OFS_STATUS:      rd_word = {11'h000, lp_osc_on, sub_clk_gate, aux_bypass,
                                   1'b1, 1'b1};
      default:          rd_hit  = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= {16'h0000, rd_word};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clock dividers and multiplexers.
  // --------------------------------------------------------------------------
  reg  src_tick;
  reg  ref_src_tick;
  wire main_div;
  wire sub_div;

  always @* begin
    case (src_sel_ff[2:0])
      3'h0:    src_tick = osc_tick;
      3'h1:    src_tick = ref_tick;
      3'h2:    src_tick = xtal_tick;
      3'h3:    src_tick = lp_tick;
      default: src_tick = osc_tick;
    endcase
    ref_src_tick = loop_ref_ff[4] ? ref_tick : xtal_tick;
  end

  pow2_divider u_main (
    .pclk    (pclk),
    .presetn (presetn),
    .en_in   (src_tick),
    .code    (div_gate_ff[2:0]),
    .en_out  (main_div)
  );

  pow2_divider u_sub (
    .pclk    (pclk),
    .presetn (presetn),
    .en_in   (main_div),
    .code    ({1'b0, div_gate_ff[5:4]}),
    .en_out  (sub_div)
  );

  // Reference divider and auxiliary divider counters.
  reg  [9:0] ref_cnt_ff;
  reg  [9:0] ref_lim;
  reg  [9:0] aux_cnt_ff;
  reg  [9:0] aux_lim;
  wire       aux_src = src_sel_ff[8] ? ref_tick : xtal_tick;

  always @* begin
    case (loop_ref_ff[2:0])
      3'h1:    ref_lim = 10'd31;
      3'h2:    ref_lim = 10'd63;
      3'h3:    ref_lim = 10'd127;
      3'h4:    ref_lim = 10'd511;
      default: ref_lim = 10'd0;
    endcase
    case (aux_xtal_ff[11:8])
      4'h1:    aux_lim = 10'd15;
      4'h2:    aux_lim = 10'd31;
      4'h3:    aux_lim = 10'd63;
      4'h4:    aux_lim = 10'd127;
      4'h5:    aux_lim = 10'd255;
      4'h6:    aux_lim = 10'd383;
      4'h7:    aux_lim = 10'd511;
      4'h8:    aux_lim = 10'd767;
      4'h9:    aux_lim = 10'd1023;
      default: aux_lim = 10'd0;
    endcase
    if (aux_bypass) begin
      aux_lim = 10'd0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_ff  <= 10'h000;
      aux_cnt_ff  <= 10'h000;
      loop_ref_en <= 1'b0;
      aux_clk_en  <= 1'b0;
      main_clk_en <= 1'b0;
      sub_clk_en  <= 1'b0;
    end else begin
      loop_ref_en <= 1'b0;
      aux_clk_en  <= 1'b0;
      main_clk_en <= main_div;
      sub_clk_en  <= sub_div & ~sub_clk_gate;
      if (ref_src_tick) begin
        if (ref_cnt_ff >= ref_lim) begin
          ref_cnt_ff  <= 10'h000;
          loop_ref_en <= 1'b1;
        end else begin
          ref_cnt_ff <= ref_cnt_ff + 10'h001;
        end
      end
      if (aux_src) begin
        if (aux_cnt_ff >= aux_lim) begin
          aux_cnt_ff <= 10'h000;
          aux_clk_en <= 1'b1;
        end else begin
          aux_cnt_ff <= aux_cnt_ff + 10'h001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Analog control outputs.
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_tap         <= 9'h000;
      applied_trim           <= `FACTORY_TRIM;
      range_select           <= 3'h1;
      lp_osc_on              <= 1'b1;
      crystal_bypass         <= 1'b0;
      crystal_high_band      <= 2'h0;
      crystal_drive_strength <= 2'h3;
    end else begin
      oscillator_tap         <= tap_mod_ff[8:0];
      applied_trim           <= trim_range_ff[7] ? trim_range_ff[6:4]
                                                 : `FACTORY_TRIM;
      range_select           <= trim_range_ff[3:1];
      lp_osc_on              <= ~div_gate_ff[12] | lp_in_use |
                                (src_sel_ff[2:0] == 3'h3);
      crystal_bypass         <= aux_xtal_ff[4];
      crystal_high_band      <= aux_xtal_ff[3:2];
      crystal_drive_strength <= aux_xtal_ff[7:6];
    end
  end
endmodule // clock_system_config_regs
`default_nettype wire

// ---- verif/clock_system_checker_asserts.sv ----
`include "clock_system_regs.vh"
`default_nettype none
module clock_system_checker (
  // Bus side.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Clock side.
  input wire logic        lp_in_use,
  input wire logic        main_clk_en,
  input wire logic        sub_clk_en,
  input wire logic [2:0]  applied_trim,
  input wire logic [2:0]  range_select,
  input wire logic        lp_osc_on,
  input wire logic        crystal_bypass,
  input wire logic [1:0]  crystal_high_band,
  input wire logic [1:0]  crystal_drive_strength
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // --------------------------------------------------------------------------
  // Shadow copies of the control bits that drive the level outputs and gate sub_clk_en.
  // --------------------------------------------------------------------------
  wire       wr_go = psel & penable & pready & pwrite;
  wire       lo_go = wr_go & pstrb[0];
  wire       hi_go = wr_go & pstrb[1];
  wire       mapped = paddr == `OFS_TAP_MOD || paddr == `OFS_TRIM_RANGE
    || paddr == `OFS_LOOP_DIVMUL || paddr == `OFS_LOOP_REF || paddr == `OFS_SRC_SEL
    || paddr == `OFS_DIV_GATE || paddr == `OFS_AUX_XTAL || paddr == `OFS_STATUS;
  reg  [7:0] trim_ff;
  reg  [7:0] xtal_ff;
  reg        sub_off_ff;
  reg        auto_off_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_ff     <= 8'h33;
      xtal_ff     <= 8'hC1;
      sub_off_ff  <= 1'b0;
      auto_off_ff <= 1'b1;
    end else begin
      if (lo_go && paddr == `OFS_TRIM_RANGE) trim_ff <= pwdata[7:0];
      if (lo_go && paddr == `OFS_AUX_XTAL) xtal_ff <= pwdata[7:0];
      if (hi_go && paddr == `OFS_DIV_GATE) sub_off_ff <= pwdata[8];
      if (hi_go && paddr == `OFS_DIV_GATE) auto_off_ff <= pwdata[12];
    end
  end

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_only_unmapped_a: assert property (pslverr |-> pready && !mapped)
    else $error("slave error on a mapped address");
  unmapped_reads_zero_a: assert property (pready && !pwrite && !mapped
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused with zero");
  upper_half_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  trim_applied_a: assert property ($stable(trim_ff) [*3] |-> range_select == trim_ff[3:1]
    && applied_trim == (trim_ff[7] ? trim_ff[6:4] : `FACTORY_TRIM))
    else $error("trim or range output wrong");
  crystal_pins_a: assert property ($stable(xtal_ff) [*3] |-> crystal_bypass == xtal_ff[4]
    && crystal_high_band == xtal_ff[3:2] && crystal_drive_strength == xtal_ff[7:6])
    else $error("crystal control outputs wrong");
  sub_gated_a: assert property (sub_off_ff [*3] |-> !sub_clk_en)
    else $error("sub clock pulses while gated");
  lp_kept_on_a: assert property ((!auto_off_ff || lp_in_use) [*3] |-> lp_osc_on)
    else $error("low-power oscillator off while needed");

  cover property (sub_off_ff && main_clk_en);
  cover property (pslverr);
  cover property (main_clk_en && sub_clk_en);
endmodule // clock_system_checker

bind clock_system_config_regs clock_system_checker u_checker (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .lp_in_use,
  .main_clk_en, .sub_clk_en, .applied_trim, .range_select, .lp_osc_on, .crystal_bypass,
  .crystal_high_band, .crystal_drive_strength);
`default_nettype wire

// ---- verif/clock_system_config_regs_test.sv ----
`include "clock_system_regs.vh"
`default_nettype none
module clock_system_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MASKS [7] = '{`MASK_TAP_MOD, `MASK_TRIM_RANGE, `MASK_LOOP_DIVMUL,
    `MASK_LOOP_REF, `MASK_SRC_SEL, `MASK_DIV_GATE, `MASK_AUX_XTAL};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic        loop_up_pin = 1'b0;
  logic        loop_down_pin = 1'b0;
  logic        osc_tick = 1'b0;
  logic        ref_tick = 1'b0;
  logic        xtal_tick = 1'b0;
  logic        lp_tick = 1'b0;
  logic        lp_in_use = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        main_clk_en;
  logic        sub_clk_en;
  logic        aux_clk_en;
  logic        loop_ref_en;
  logic [8:0]  oscillator_tap;
  logic [2:0]  applied_trim;
  logic [2:0]  range_select;
  logic        lp_osc_on;
  logic        crystal_bypass;
  logic [1:0]  crystal_high_band;
  logic [1:0]  crystal_drive_strength;
  logic [15:0] exp_q [7];
  logic [31:0] rd_v;
  logic        err_v;
  logic [15:0] d;
  int          errors = 0;
  int          checks_done = 0;
  int          tk [4];
  int          pc [4];
  int          i;

  always #20 pclk = ~pclk;

  clock_system_config_regs u_clock_system_config_regs (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .loop_up_pin,
    .loop_down_pin, .osc_tick, .ref_tick, .xtal_tick, .lp_tick, .lp_in_use, .main_clk_en,
    .sub_clk_en, .aux_clk_en, .loop_ref_en, .oscillator_tap, .applied_trim, .range_select,
    .lp_osc_on, .crystal_bypass, .crystal_high_band, .crystal_drive_strength);

  // --------------------------------------------------------------------------
  // Expectation model and compare helpers.
  // --------------------------------------------------------------------------
  function automatic logic [15:0] model(input int idx, input logic [15:0] old,
                                        input logic [15:0] wd, input logic [1:0] st);
    logic [15:0] n;
    n = old;
    if (st[0]) n[7:0] = wd[7:0];
    if (st[1]) n[15:8] = wd[15:8];
    n = n & MASKS[idx];
    case (idx)
      2: begin
        if (n[14:12] > 3'h5) n[14:12] = old[14:12];
        if (n[9:0] == 10'h000) n[9:0] = 10'h001;
      end
      3: begin
        if (n[5:4] > 2'h1) n[5:4] = old[5:4];
        if (n[2:0] > 3'h4) n[2:0] = old[2:0];
      end
      4: if (n[2]) n[2:0] = old[2:0];
      6: if (n[11:8] > 4'h9) n[11:8] = old[11:8];
      default: ;
    endcase
    return n;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A divided count may gain one pulse from the divider phase left before.
  task automatic chk_rng(input string nm, input int lo, input int g);
    checks_done++;
    if (g != lo && g != lo + 1) begin
      errors++;
      $display("BAD %s expected %0d seen %0d", nm, lo, g);
    end
  endtask

  // --------------------------------------------------------------------------
  // APB master, one idle cycle after each transfer.
  // --------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] dd,
                     input logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'($urandom), dd};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input int idx, input logic [15:0] dd);
    apb(1'b1, 12'(idx * 8), dd, 4'h3);
    exp_q[idx] = model(idx, exp_q[idx], dd, 2'h3);
  endtask

  task automatic rd_chk(input int idx);
    apb(1'b0, 12'(idx * 8), 16'h0000, 4'h0);
    chk("register", {16'h0000, exp_q[idx]}, rd_v);
    chk("slave error", 32'h0, {31'h0, err_v});
  endtask

  task automatic step(input logic up);
    logic [15:0] v;
    v = exp_q[0];
    if (up) loop_up_pin <= 1'b1;
    else loop_down_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    loop_up_pin <= 1'b0;
    loop_down_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    if (exp_q[1][0]) v[8:0] = up ? v[8:0] + 9'h001 : v[8:0] - 9'h001;
    else if (up) begin
      v[13:9] = v[13:9] + 5'h01;
      if (v[13:9] == 5'h00) v[8:0] = v[8:0] + 9'h001;
    end else begin
      if (v[13:9] == 5'h00) v[8:0] = v[8:0] - 9'h001;
      v[13:9] = v[13:9] - 5'h01;
    end
    exp_q[0] = v;
  endtask

  // Random source ticks for n cycles, then quiet cycles to drain pulses.
  task automatic run_win(input int n);
    int k;
    tk = '{default: 0};
    pc = '{default: 0};
    for (int c = 0; c < n + 10; c++) begin
      @(posedge pclk);
      pc[0] += main_clk_en;
      pc[1] += sub_clk_en;
      pc[2] += aux_clk_en;
      pc[3] += loop_ref_en;
      k = (c < n) ? $urandom : 0;
      osc_tick <= k[0];
      ref_tick <= k[1];
      xtal_tick <= k[2];
      lp_tick <= k[3];
      lp_in_use <= k[4];
      for (int s = 0; s < 4; s++) tk[s] += k[s];
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 40000);
    errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hDC1964D7));
    exp_q = '{`RST_TAP_MOD, `RST_TRIM_RANGE, `RST_LOOP_DIVMUL, `RST_LOOP_REF, `RST_SRC_SEL,
      `RST_DIV_GATE, `RST_AUX_XTAL};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 7; i++) rd_chk(i);
    $display("test reset values done");
    for (i = 0; i < 150; i++) begin
      automatic int idx = $urandom % 7;
      automatic logic [3:0] s = {2'($urandom), 2'(1 + $urandom % 3)};
      d = $urandom;
      if (idx == 1 && d[3:2] == 2'h3) d[2] = 1'b0;
      if (idx == 3 && d[2:0] == 3'h5) d[0] = 1'b0;
      apb(1'b1, 12'(idx * 8), d, s);
      exp_q[idx] = model(idx, exp_q[idx], d, s[1:0]);
      rd_chk(idx);
    end
    $display("test random access done");
    apb(1'b1, 12'h024, 16'hFFFF, 4'h3);
    chk("write refused", 32'h1, {31'h0, err_v});
    apb(1'b0, 12'hFFC, 16'h0000, 4'h0);
    chk("read refused", 32'h1, {31'h0, err_v});
    for (i = 0; i < 7; i++) rd_chk(i);
    $display("test unmapped done");
    for (i = 0; i < 8; i++) begin
      wr(1, {8'h00, exp_q[1][7:1], i >= 6});
      d = $urandom;
      d[8:0] = 9'h002 + 9'($urandom % 500);
      if (i < 4) d[13:9] = i[0] ? 5'h00 : 5'h1F;
      wr(0, d);
      step(!i[0]);
      rd_chk(0);
      chk("tap output", {23'h0, exp_q[0][8:0]}, {23'h0, oscillator_tap});
    end
    $display("test loop steps done");
    for (i = 0; i < 4; i++) begin
      wr(4, {13'h0080, 3'(i)});
      wr(5, {10'h040, 2'(3 - i), 1'b0, 3'(i)});
      wr(3, {8'h00, 2'h0, 2'(i % 2), 1'b0, (i == 3) ? 3'h1 : 3'h0});
      run_win(300);
      chk_rng("main pulses", tk[i] >> i, pc[0]);
      chk_rng("sub pulses", tk[i] >> 3, pc[1]);
      chk_rng("ref pulses", (i == 3) ? tk[1] / 32 : tk[2 - i % 2], pc[3]);
    end
    wr(5, 16'h1100);
    run_win(100);
    chk("gated sub pulses", 32'h0, 32'(pc[1]));
    wr(5, 16'h1000);
    wr(4, 16'h0000);
    wr(6, 16'h01C1);
    run_win(300);
    chk_rng("aux pulses", tk[2], pc[2]);
    wr(6, 16'h01E1);
    run_win(300);
    chk_rng("aux pulses", tk[2] / 16, pc[2]);
    wr(4, 16'h0100);
    wr(6, 16'h00C1);
    run_win(200);
    chk_rng("aux pulses", tk[1], pc[2]);
    wr(4, 16'h0002);
    wr(4, 16'h0006);
    run_win(200);
    chk_rng("main pulses", tk[2], pc[0]);
    apb(1'b0, `OFS_STATUS, 16'h0000, 4'h0);
    chk("status", 32'h0000_0007, rd_v);
    $display("test clock outputs done");
    end_of_test();
  end
endmodule // clock_system_config_regs_test
`default_nettype wire
